// >>> iybcs_addr_gen.sv
/*
 * Address generator: turns an address source into a bus address.
 * Assumes the operands are stable for the cycle in which they are used.
 */
`timescale 1ns/1ps
`include "iybcs_map.svh"

module iybcs_addr_gen
(
    // Selection
    input  wire iybcs_pkg::iybcs_asel_t asel,
    // Address operands
    input  wire logic [15:0]            opc,
    input  wire logic [15:0]            eff,
    input  wire logic [15:0]            sp,
    // Result
    output logic [15:0]                 addr
);
    import iybcs_pkg::*;

    // Source mux with small offsets
    always_comb
    begin
        unique case (asel)
            A_OPC:   addr = opc;
            A_OPC1:  addr = opc + 16'h0001;
            A_OPC2:  addr = opc + 16'h0002;
            A_OPC3:  addr = opc + 16'h0003;
            A_OPC4:  addr = opc + 16'h0004;
            A_EFF:   addr = eff;
            A_EFF1:  addr = eff + 16'h0001;
            A_SP:    addr = sp;
            A_SPM1:  addr = sp - 16'h0001;
            default: addr = `IYBCS_DUMMY_ADDR;
        endcase
    end
endmodule

// >>> iybcs_map.svh
/*
 * Constants for the Y-indexed bus cycle sequencer.
 * Assumes a 16-bit address bus and an 8-bit data bus.
 */
`ifndef IYBCS_MAP_SVH
`define IYBCS_MAP_SVH

// Fixed bytes and addresses
`define IYBCS_PREFIX_Y      8'h18
`define IYBCS_OP2_JUMP      8'h6e
`define IYBCS_OP2_TEST      8'h6d
`define IYBCS_OP2_CALL      8'had
`define IYBCS_DUMMY_ADDR    16'hffff

// Cycle counts per instruction group
`define IYBCS_CYC_JUMP      4'h4
`define IYBCS_CYC_ACC_READ  4'h5
`define IYBCS_CYC_RMW       4'h7
`define IYBCS_CYC_TEST      4'h7
`define IYBCS_CYC_ACC_STORE 4'h5
`define IYBCS_CYC_LOAD16    4'h6
`define IYBCS_CYC_STORE16   4'h6
`define IYBCS_CYC_ARITH16   4'h7
`define IYBCS_CYC_CALL      4'h7
`define IYBCS_CYC_BIT_MEM   4'h8
`define IYBCS_CYC_BRANCH    4'h8

`endif

// >>> iybcs_mem_model.sv
/* Memory model on the far side of the address/data bus.
   Assumes one bus cycle per clock and no wait states. */
`timescale 1ns/1ps
module iybcs_mem_model
(
    // Clock
    input  wire logic        core_clk,
    // Bus from the sequencer
    input  wire logic [15:0] bus_addr,
    input  wire logic        bus_rw,
    input  wire logic [7:0]  bus_dout,
    input  wire logic        bus_dout_en,
    // Read data
    output logic [7:0]       bus_din
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_din = 8'h00;
    // Unwritten bytes hold a pattern made from the address
    initial
        for (int i = 0; i < 65536; i++)
            mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
    function automatic logic [7:0] peek(input logic [15:0] a);
        return mem[a];
    endfunction
    function automatic void put(input logic [15:0] a, input logic [7:0] d);
        mem[a] = d;
    endfunction
    // Reads answer at once; write cycles see the inverse of the last byte
    assign bus_din = bus_rw ? peek(bus_addr) : ~last_din;
    // Store written bytes, remember the last byte read
    always @(posedge core_clk)
    begin
        if (bus_rw === 1'b0 && bus_dout_en === 1'b1)
            mem[bus_addr] <= bus_dout;
        if (bus_rw === 1'b1)
            last_din <= bus_din;
    end
endmodule

// >>> iybcs_pkg.sv
/*
 * Types for the Y-indexed bus cycle sequencer.
 * Assumes nothing beyond the constants header.
 */
package iybcs_pkg;

    // Instruction groups sharing one cycle pattern
    typedef enum logic [3:0] {
        G_JUMP, G_ACC_READ, G_RMW, G_TEST, G_ACC_STORE, G_LOAD16,
        G_STORE16, G_ARITH16, G_CALL, G_BIT_MEM, G_BRANCH_BITS
    } iybcs_group_t;

    // Address source of a bus cycle
    typedef enum logic [3:0] {
        A_OPC, A_OPC1, A_OPC2, A_OPC3, A_OPC4, A_DUMMY,
        A_EFF, A_EFF1, A_SP, A_SPM1
    } iybcs_asel_t;

    // Meaning of the data byte of a bus cycle
    typedef enum logic [3:0] {
        K_PREFIX, K_OPCODE2, K_OFFSET, K_DUMMY, K_OPERAND, K_OPERAND_HI,
        K_OPERAND_LO, K_RESULT, K_ACC, K_REG_HI, K_REG_LO, K_SUB_OPCODE,
        K_RET_LO, K_RET_HI, K_MASK, K_BR_OFFSET
    } iybcs_kind_t;

    typedef enum logic {
        P_IDLE, P_RUN
    } iybcs_phase_t;

    // One line of the cycle table
    typedef struct packed {
        iybcs_asel_t asel;
        logic        rw;
        iybcs_kind_t kind;
    } iybcs_plan_t;

endpackage

// >>> iybcs_sequencer.sv
/*
 * Y-indexed bus cycle sequencer: one bus cycle per clock for each
 * Y-indexed instruction group, driving address, read/write and data.
 * Assumes the core holds its request inputs while busy and presents
 * the result byte before the edge that opens a result write.
 */
// Summary of operation
// (RL1) Cycle 1 reads prefix at opcode address, cycle 2 second opcode at plus one.
// (RL2) Cycle 3 reads offset at plus two; cycle 4 dummy-reads all-ones.
// (RL3) Jump takes four cycles, second byte fixed, ends with the dummy read.
// (RL4) Accumulator reads take five cycles, operand read at Y plus offset.
// (RL5) Read-modify-write: read, dummy read, write result; seven cycles.
// (RL6) Test takes seven cycles: operand read, two dummy reads, no write.
// (RL7) Accumulator stores take five cycles, writing accumulator at Y plus offset.
// (RL8) 16-bit loads take six cycles, high byte then low at plus one.
// (RL9) 16-bit stores take six cycles, writing high then low byte.
// (RL10) 16-bit arithmetic takes seven cycles, ends with a dummy read.
// (RL11) Subroutine call takes seven cycles; cycle five reads the target opcode.
// (RL12) Call writes return low at stack pointer, high at stack pointer minus one.
// (RL13) Memory bit set/clear: read, mask at plus three, dummy, write; eight cycles.
// (RL14) Branch on bits: read, mask, branch offset, dummy read; eight cycles.
`timescale 1ns/1ps
`include "iybcs_map.svh"

module iybcs_sequencer
#(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 8
)
(
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    srst,
    // Core request
    input  wire logic                    start,
    input  wire iybcs_pkg::iybcs_group_t group,
    input  wire logic [ADDR_W-1:0]       opcode_addr,
    input  wire logic [ADDR_W-1:0]       y_index_register,
    input  wire logic [ADDR_W-1:0]       stack_ptr,
    input  wire logic [DATA_W-1:0]       acc_byte,
    input  wire logic [2*DATA_W-1:0]     reg_word,
    input  wire logic [ADDR_W-1:0]       return_addr,
    input  wire logic [DATA_W-1:0]       result_byte,
    // Core status
    output logic                         ready,
    output logic                         busy,
    output logic                         done,
    output logic [3:0]                   cycle_num,
    output logic                         opcode2_err,
    output logic                         rd_valid,
    output iybcs_pkg::iybcs_kind_t       rd_kind,
    output logic [DATA_W-1:0]            rd_data,
    output logic [ADDR_W-1:0]            eff_addr,
    // Address/data bus
    output logic [ADDR_W-1:0]            bus_addr,
    output logic                         bus_rw,
    output logic [DATA_W-1:0]            bus_dout,
    output logic                         bus_dout_en,
    output iybcs_pkg::iybcs_kind_t       bus_kind,
    input  wire logic [DATA_W-1:0]       bus_din
);
    import iybcs_pkg::*;

    // Widths the logic is built for
    if (ADDR_W != 16 || DATA_W != 8)
    begin : g_width_check
        $error("iybcs_sequencer supports only a 16-bit address and 8-bit data");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cycle table

    // Number of bus cycles of a group
    function automatic logic [3:0] cycle_count(input iybcs_group_t g);
        unique case (g)
            G_JUMP:        cycle_count = `IYBCS_CYC_JUMP;
            G_ACC_READ:    cycle_count = `IYBCS_CYC_ACC_READ;
            G_RMW:         cycle_count = `IYBCS_CYC_RMW;
            G_TEST:        cycle_count = `IYBCS_CYC_TEST;
            G_ACC_STORE:   cycle_count = `IYBCS_CYC_ACC_STORE;
            G_LOAD16:      cycle_count = `IYBCS_CYC_LOAD16;
            G_STORE16:     cycle_count = `IYBCS_CYC_STORE16;
            G_ARITH16:     cycle_count = `IYBCS_CYC_ARITH16;
            G_CALL:        cycle_count = `IYBCS_CYC_CALL;
            G_BIT_MEM:     cycle_count = `IYBCS_CYC_BIT_MEM;
            G_BRANCH_BITS: cycle_count = `IYBCS_CYC_BRANCH;
            default:       cycle_count = `IYBCS_CYC_JUMP;
        endcase
    endfunction

    // Address source, direction and data meaning of cycle n of group g
    function automatic iybcs_plan_t cycle_plan(input iybcs_group_t g, input logic [3:0] n);
        iybcs_plan_t p;
        p = '{A_DUMMY, 1'b1, K_DUMMY};
        unique case (n)
            4'h1: p = '{A_OPC, 1'b1, K_PREFIX};                             // [RL1]
            4'h2: p = '{A_OPC1, 1'b1, K_OPCODE2};                           // [RL1]
            4'h3: p = '{A_OPC2, 1'b1, K_OFFSET};                            // [RL2]
            4'h4: p = '{A_DUMMY, 1'b1, K_DUMMY};                            // [RL2] [RL3]
            4'h5:
            begin
                unique case (g)
                    G_ACC_STORE: p = '{A_EFF, 1'b0, K_ACC};                 // [RL7]
                    G_LOAD16,
                    G_ARITH16:   p = '{A_EFF, 1'b1, K_OPERAND_HI};          // [RL8] [RL10]
                    G_STORE16:   p = '{A_EFF, 1'b0, K_REG_HI};              // [RL9]
                    G_CALL:      p = '{A_EFF, 1'b1, K_SUB_OPCODE};          // [RL11]
                    default:     p = '{A_EFF, 1'b1, K_OPERAND};             // [RL4] [RL5] [RL6]
                endcase
            end
            4'h6:
            begin
                unique case (g)
                    G_LOAD16,
                    G_ARITH16:     p = '{A_EFF1, 1'b1, K_OPERAND_LO};       // [RL8] [RL10]
                    G_STORE16:     p = '{A_EFF1, 1'b0, K_REG_LO};           // [RL9]
                    G_CALL:        p = '{A_SP, 1'b0, K_RET_LO};             // [RL12]
                    G_BIT_MEM,
                    G_BRANCH_BITS: p = '{A_OPC3, 1'b1, K_MASK};             // [RL13] [RL14]
                    default:       p = '{A_DUMMY, 1'b1, K_DUMMY};           // [RL5] [RL6]
                endcase
            end
            4'h7:
            begin
                unique case (g)
                    G_RMW:         p = '{A_EFF, 1'b0, K_RESULT};            // [RL5]
                    G_CALL:        p = '{A_SPM1, 1'b0, K_RET_HI};           // [RL12]
                    G_BRANCH_BITS: p = '{A_OPC4, 1'b1, K_BR_OFFSET};        // [RL14]
                    default:       p = '{A_DUMMY, 1'b1, K_DUMMY};           // [RL6] [RL10] [RL13]
                endcase
            end
            4'h8:
            begin
                if (g == G_BIT_MEM)
                    p = '{A_EFF, 1'b0, K_RESULT};                           // [RL13]
                else
                    p = '{A_DUMMY, 1'b1, K_DUMMY};                          // [RL14]
            end
            default: p = '{A_DUMMY, 1'b1, K_DUMMY};
        endcase
        return p;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        iybcs_phase_t phase;
        iybcs_group_t group;
        logic [3:0]   cyc;
        logic [15:0]  opc;
        logic [15:0]  yreg;
        logic [15:0]  eff;
        logic [15:0]  sp;
        logic [7:0]   acc;
        logic [15:0]  regw;
        logic [15:0]  ret;
        logic [15:0]  addr;
        logic         rw;
        logic [7:0]   dout;
        logic         dout_en;
        iybcs_kind_t  kind;
        logic         done;
        logic         err;
        logic         rd_valid;
        iybcs_kind_t  rd_kind;
        logic [7:0]   rd_data;
    } iybcs_state_t;

    iybcs_state_t s;
    iybcs_state_t next_s;
    iybcs_plan_t  next_plan;
    logic [3:0]   next_cyc;
    logic [15:0]  next_addr;
    logic [15:0]  gen_opc;
    logic [15:0]  gen_eff;
    logic [15:0]  gen_sp;
    logic         take;

    assign take     = start && (s.phase == P_IDLE);
    assign next_cyc = take ? 4'h1 : s.cyc + 4'h1;
    assign gen_opc  = take ? opcode_addr : s.opc;
    assign gen_eff  = s.eff;
    assign gen_sp   = take ? stack_ptr : s.sp;

    always_comb
    begin
        next_plan = cycle_plan(take ? group : s.group, next_cyc);
    end

    // Address of the coming bus cycle
    iybcs_addr_gen u_addr_gen
    (
        .asel (next_plan.asel),
        .opc  (gen_opc),
        .eff  (gen_eff),
        .sp   (gen_sp),
        .addr (next_addr)
    );

    // Sequencing of bus cycles and capture of read bytes
    always_comb
    begin
        next_s          = s;
        next_s.rd_valid = 1'b0;
        next_s.done     = 1'b0;
        if (s.phase == P_RUN && s.rw)
        begin
            next_s.rd_valid = 1'b1;
            next_s.rd_kind  = s.kind;
            next_s.rd_data  = bus_din;
            if (s.kind == K_OFFSET)
                next_s.eff = s.yreg + {8'h00, bus_din};                     // [RL4]
            if (s.kind == K_OPCODE2)
            begin
                unique case (s.group)
                    G_JUMP: next_s.err = (bus_din != `IYBCS_OP2_JUMP);      // [RL3]
                    G_TEST: next_s.err = (bus_din != `IYBCS_OP2_TEST);      // [RL6]
                    G_CALL: next_s.err = (bus_din != `IYBCS_OP2_CALL);      // [RL11]
                    default: next_s.err = 1'b0;
                endcase
            end
        end
        if (take)
        begin
            next_s.phase = P_RUN;
            next_s.group = group;
            next_s.opc   = opcode_addr;
            next_s.yreg  = y_index_register;
            next_s.sp    = stack_ptr;
            next_s.acc   = acc_byte;
            next_s.regw  = reg_word;
            next_s.ret   = return_addr;
            next_s.err   = 1'b0;
        end
        else if (s.phase == P_RUN && s.done)
            next_s.phase = P_IDLE;
        if (next_s.phase == P_RUN)
        begin
            next_s.cyc     = next_cyc;
            next_s.addr    = next_addr;
            next_s.rw      = next_plan.rw;
            next_s.kind    = next_plan.kind;
            next_s.dout_en = !next_plan.rw;
            next_s.done    = (next_cyc == cycle_count(next_s.group));
            unique case (next_plan.kind)
                K_ACC:    next_s.dout = next_s.acc;                         // [RL7]
                K_RESULT: next_s.dout = result_byte;                        // [RL5] [RL13]
                K_REG_HI: next_s.dout = next_s.regw[15:8];                  // [RL9]
                K_REG_LO: next_s.dout = next_s.regw[7:0];                   // [RL9]
                K_RET_LO: next_s.dout = next_s.ret[7:0];                    // [RL12]
                K_RET_HI: next_s.dout = next_s.ret[15:8];                   // [RL12]
                default:  next_s.dout = 8'h00;
            endcase
        end
        else
        begin
            next_s.cyc     = 4'h0;
            next_s.addr    = `IYBCS_DUMMY_ADDR;
            next_s.rw      = 1'b1;
            next_s.dout    = 8'h00;
            next_s.dout_en = 1'b0;
            next_s.kind    = K_DUMMY;
        end
    end

    // State register
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            s      <= '0;
            s.addr <= `IYBCS_DUMMY_ADDR;
            s.rw   <= 1'b1;
            s.kind <= K_DUMMY;
        end
        else
            s <= next_s;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign ready       = (s.phase == P_IDLE);
    assign busy        = (s.phase == P_RUN);
    assign done        = s.done;
    assign cycle_num   = s.cyc;
    assign opcode2_err = s.err;
    assign rd_valid    = s.rd_valid;
    assign rd_kind     = s.rd_kind;
    assign rd_data     = s.rd_data;
    assign eff_addr    = s.eff;
    assign bus_addr    = s.addr;
    assign bus_rw      = s.rw;
    assign bus_dout    = s.dout;
    assign bus_dout_en = s.dout_en;
    assign bus_kind    = s.kind;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    a_prefix_first: assert property (take |=> bus_kind == K_PREFIX && bus_rw   // [RL1]
        && bus_addr == $past(opcode_addr)) else $error("prefix cycle wrong");
    a_second_fetch: assert property (busy && bus_kind == K_PREFIX |=>           // [RL1]
        bus_kind == K_OPCODE2 && bus_addr == $past(bus_addr) + 16'h0001) else $error("second byte wrong");
    a_offset_dummy: assert property (busy && bus_kind == K_OFFSET |=>           // [RL2]
        bus_kind == K_DUMMY && bus_addr == 16'hffff && bus_rw && cycle_num == 4'h4) else $error("dummy wrong");
    a_jump_length: assert property (take && group == G_JUMP |->                 // [RL3]
        !done [*4] ##1 done ##1 ready) else $error("jump length wrong");
    a_acc_read_len: assert property (take && group == G_ACC_READ |->            // [RL4]
        ##5 done && bus_rw && bus_addr == s.eff) else $error("operand read wrong");
    a_rmw_write: assert property (busy && s.group == G_RMW && cycle_num == 4'h6 // [RL5]
        |-> bus_addr == 16'hffff ##1 !bus_rw && bus_addr == s.eff && done) else $error("rmw write wrong");
    a_test_no_write: assert property (busy && s.group == G_TEST |-> bus_rw     // [RL6]
        && !bus_dout_en) else $error("test wrote");
    a_test_length: assert property (take && group == G_TEST |->                 // [RL6]
        ##7 done && bus_addr == 16'hffff) else $error("test length wrong");
    a_acc_store: assert property (busy && bus_kind == K_ACC |-> !bus_rw         // [RL7]
        && bus_dout == s.acc && cycle_num == 4'h5 && done) else $error("acc store wrong");
    a_load_pair: assert property (busy && s.group == G_LOAD16 && bus_kind ==    // [RL8]
        K_OPERAND_HI |=> bus_kind == K_OPERAND_LO && bus_addr == $past(bus_addr) + 16'h0001 && done)
        else $error("load pair wrong");
    a_store_pair: assert property (busy && bus_kind == K_REG_HI |-> !bus_rw     // [RL9]
        ##1 bus_kind == K_REG_LO && !bus_rw && bus_dout == s.regw[7:0] && done) else $error("store pair wrong");
    a_arith_tail: assert property (take && group == G_ARITH16 |->               // [RL10]
        ##7 done && bus_addr == 16'hffff && bus_rw) else $error("arith tail wrong");
    a_call_target: assert property (busy && s.group == G_CALL && cycle_num ==   // [RL11]
        4'h5 |-> bus_kind == K_SUB_OPCODE && bus_addr == s.eff && bus_rw) else $error("call target wrong");
    a_call_stack: assert property (busy && bus_kind == K_RET_LO |->             // [RL12]
        bus_addr == s.sp && !bus_rw ##1 bus_kind == K_RET_HI && bus_addr == s.sp - 16'h0001 && !bus_rw)
        else $error("call stack wrong");
    a_bit_mem_seq: assert property (take && group == G_BIT_MEM |->              // [RL13]
        ##6 bus_kind == K_MASK && bus_addr == s.opc + 16'h0003 ##2 !bus_rw && done) else $error("bit op wrong");
    a_branch_bits: assert property (take && group == G_BRANCH_BITS |->          // [RL14]
        ##7 bus_addr == s.opc + 16'h0004 ##1 bus_addr == 16'hffff && bus_rw && done) else $error("branch wrong");

    c_jump_done: cover property (take && group == G_JUMP ##4 done);
    c_rmw_done: cover property (take && group == G_RMW ##7 done);
    c_call_done: cover property (take && group == G_CALL ##7 done);
    c_bit_mem_done: cover property (take && group == G_BIT_MEM ##8 done);
endmodule

// >>> tb_top.sv
/* Testbench: runs every instruction group against the memory model.
   Assumes the sequencer with its default 16/8 widths. */
`timescale 1ns/1ps
module tb_top;
    import iybcs_pkg::*;
    typedef struct {
        logic [15:0] addr;
        logic        rw;
        logic [7:0]  dout;
        iybcs_kind_t kind;
        logic [7:0]  din;
        logic        last;
        logic [3:0]  cyc;
    } iybcs_note_t;
    logic core_clk = 1'b0, srst = 1'b1, start = 1'b0;
    iybcs_group_t group = G_JUMP;
    logic [15:0] opcode_addr = 16'h0, y_index_register = 16'h0, stack_ptr = 16'h0;
    logic [15:0] reg_word = 16'h0, return_addr = 16'h0;
    logic [7:0] acc_byte = 8'h0, result_byte = 8'h0, rd_data, bus_dout, bus_din;
    logic ready, busy, done, opcode2_err, rd_valid, bus_rw, bus_dout_en;
    logic [3:0] cycle_num;
    logic [15:0] eff_addr, bus_addr;
    iybcs_kind_t rd_kind, bus_kind;
    iybcs_note_t q[$];
    iybcs_note_t e, pend;
    logic pend_ok = 1'b0;
    int num_errors = 0, checks = 0, ncyc = 0;

    iybcs_sequencer dut_u (.core_clk, .srst, .start, .group, .opcode_addr, .y_index_register,
        .stack_ptr, .acc_byte, .reg_word, .return_addr, .result_byte, .ready, .busy, .done,
        .cycle_num, .opcode2_err, .rd_valid, .rd_kind, .rd_data, .eff_addr, .bus_addr, .bus_rw,
        .bus_dout, .bus_dout_en, .bus_kind, .bus_din);
    iybcs_mem_model mem_u (.core_clk, .bus_addr, .bus_rw, .bus_dout, .bus_dout_en, .bus_din);

    // Clock
    always #10 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////
    // Compare and closing
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Note one expected bus cycle
    task automatic note(input logic [15:0] a, input logic rw, input logic [7:0] d, input iybcs_kind_t k);
        iybcs_note_t n;
        ncyc++;
        n = '{a, rw, d, k, rw ? mem_u.peek(a) : 8'h00, 1'b0, 4'(ncyc)};
        q.push_back(n);
    endtask

    // One instruction: note its cycle table, request it, wait for done
    task automatic run(input iybcs_group_t g, input logic [7:0] op2, input logic [7:0] off,
                       input logic [15:0] y, input logic poke);
        logic [15:0] opc, eff, sp, w, ret;
        logic [7:0] acc, res;
        int n;
        opc = 16'h2000 + 16'($urandom_range(0, 4095));
        sp = 16'h0100 + 16'($urandom_range(1, 255));
        w = 16'($urandom);
        ret = 16'($urandom);
        acc = 8'($urandom);
        res = 8'($urandom);
        eff = y + {8'h00, off};
        mem_u.put(opc, 8'h18);
        mem_u.put(opc + 16'h1, op2);
        mem_u.put(opc + 16'h2, off);
        ncyc = 0;
        note(opc, 1, 0, K_PREFIX);
        note(opc + 16'h1, 1, 0, K_OPCODE2);
        note(opc + 16'h2, 1, 0, K_OFFSET);
        note(16'hffff, 1, 0, K_DUMMY);
        case (g)
            G_ACC_READ: note(eff, 1, 0, K_OPERAND);
            G_RMW:
            begin
                note(eff, 1, 0, K_OPERAND);
                note(16'hffff, 1, 0, K_DUMMY);
                note(eff, 0, res, K_RESULT);
            end
            G_TEST:
            begin
                note(eff, 1, 0, K_OPERAND);
                note(16'hffff, 1, 0, K_DUMMY);
                note(16'hffff, 1, 0, K_DUMMY);
            end
            G_ACC_STORE: note(eff, 0, acc, K_ACC);
            G_LOAD16, G_ARITH16:
            begin
                note(eff, 1, 0, K_OPERAND_HI);
                note(eff + 16'h1, 1, 0, K_OPERAND_LO);
                if (g == G_ARITH16)
                    note(16'hffff, 1, 0, K_DUMMY);
            end
            G_STORE16:
            begin
                note(eff, 0, w[15:8], K_REG_HI);
                note(eff + 16'h1, 0, w[7:0], K_REG_LO);
            end
            G_CALL:
            begin
                note(eff, 1, 0, K_SUB_OPCODE);
                note(sp, 0, ret[7:0], K_RET_LO);
                note(sp - 16'h1, 0, ret[15:8], K_RET_HI);
            end
            G_BIT_MEM, G_BRANCH_BITS:
            begin
                note(eff, 1, 0, K_OPERAND);
                note(opc + 16'h3, 1, 0, K_MASK);
                if (g == G_BRANCH_BITS)
                    note(opc + 16'h4, 1, 0, K_BR_OFFSET);
                else
                    note(16'hffff, 1, 0, K_DUMMY);
                note(g == G_BIT_MEM ? eff : 16'hffff, g != G_BIT_MEM, g == G_BIT_MEM ? res : 8'h00,
                     g == G_BIT_MEM ? K_RESULT : K_DUMMY);
            end
            default: ;
        endcase
        q[q.size() - 1].last = 1'b1;
        group <= g;
        opcode_addr <= opc;
        y_index_register <= y;
        stack_ptr <= sp;
        acc_byte <= acc;
        reg_word <= w;
        return_addr <= ret;
        result_byte <= res;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
            if (n == 2 || n == 3)
                start <= poke && n == 2;
        end
        while (done !== 1'b1 && n < 12);
        if (n >= 12)
            chk(done, 1'b1);
        chk(eff_addr, eff);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Monitor: each bus cycle against the oldest note
    always @(negedge core_clk)
    begin
        if (pend_ok)
        begin
            chk(rd_valid, 1'b1);
            chk(rd_kind, pend.kind);
            if (pend.kind !== K_DUMMY)
                chk(rd_data, pend.din);
        end
        else if (srst === 1'b0)
            chk(rd_valid, 1'b0);
        pend_ok = 1'b0;
        if (busy === 1'b1 && q.size() == 0)
            chk(busy, 1'b0);
        else if (busy === 1'b1)
        begin
            e = q.pop_front();
            chk(bus_addr, e.addr);
            chk(bus_rw, e.rw);
            chk(bus_dout_en, !e.rw);
            chk(bus_dout, e.dout);
            chk(bus_kind, e.kind);
            chk(done, e.last);
            chk(cycle_num, e.cyc);
            pend = e;
            pend_ok = e.rw;
        end
    end

    // Watchdog
    initial
    begin
        #(20 * 3000);
        num_errors++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        iybcs_group_t grp;
        void'($urandom(92));
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        chk(ready, 1'b1);
        chk(bus_addr, 16'hffff);
        chk(bus_rw, 1'b1);
        chk(cycle_num, 4'h0);
        $display("test reset done");
        for (int i = 0; i < 33; i++)
        begin
            grp = iybcs_group_t'(i % 11);
            run(grp, grp == G_JUMP ? 8'h6e : grp == G_TEST ? 8'h6d : grp == G_CALL ? 8'had
                : 8'($urandom), 8'($urandom), 16'($urandom), i > 21);
            chk(opcode2_err, 1'b0);
        end
        $display("test all groups done");
        run(G_LOAD16, 8'hec, 8'hff, 16'hff00, 1'b0);
        run(G_STORE16, 8'hed, 8'hff, 16'hff00, 1'b0);
        $display("test address wrap done");
        run(G_JUMP, 8'h6f, 8'h10, 16'h3000, 1'b0);
        chk(opcode2_err, 1'b1);
        run(G_CALL, 8'had, 8'h20, 16'h3000, 1'b0);
        chk(opcode2_err, 1'b0);
        run(G_TEST, 8'h6e, 8'h01, 16'h4000, 1'b0);
        chk(opcode2_err, 1'b1);
        $display("test second byte done");
        @(posedge core_clk);
        finish_test();
    end
endmodule
